// [hdl/dspdec_defines.vh]
// Purpose: Field positions, codes and reset values for the instruction decoder.
// Assumes: Included by bare name from the decoder.
// Notes:   Definitions only.
`ifndef DSPDEC_DEFINES_VH
`define DSPDEC_DEFINES_VH
// Instruction word fields.
`define F_T       15:11
`define F_ACC     10
`define F_SRC     9
`define F_FUNC    8:5
`define F_F1_HI   8:7
`define F_X       4
`define F_PTR     3:2
`define F_MOD     1:0
`define F_CON     4:0
`define F_B       10:8
`define F_B_TOP   10
`define F_B_KIND  9:8
`define F_SI      10
`define F_R       9:4
`define F_I       10:9
`define F_M       8:0
`define F_NI      10:7
`define F_K       6:0
`define F_JA      11:0
// Operation classes on op_class_out.
`define C_NOP     4'h0
`define C_JUMP    4'h1
`define C_CALL    4'h2
`define C_MAC     4'h3
`define C_SPECIAL 4'h4
`define C_BR_IND  4'h5
`define C_SWI     4'h6
`define C_MOVE    4'h7
`define C_IMM     4'h8
`define C_SHORT   4'h9
`define C_CACHE   4'hA
// Function, condition and register codes.
`define F1_PONLY  4'h2
`define F1_NOP    4'h6
`define F1_TAND   4'hA
`define F1_TSUB   4'hB
`define F2_RSVD   4'hA
`define F2_SHL8   4'h5
`define CON_MAX   5'h11
`define R_GAP_LO  6'h0C
`define R_GAP_HI  6'h0F
`define R_MAX     6'h1E
`define R_J       6'h04
`define R_K       6'h05
`define R_I       6'h0B
`define R_AUC     6'h13
`define R_PSW     6'h14
`define R_SIOC    6'h18
`define R_SRTA    6'h19
`define R_TDMS    6'h1B
`define R_PIOC    6'h1C
// Register layouts.
`define SRTA_RX   15:8
`define SRTA_TX   7:0
`define PSW_FLAGS 15:12
`define PSW_ACC   9:0
`define AUC_CLR   6:4
`define AUC_SAT   3:2
`define AUC_ALIGN 1:0
`define ALIGN_RSVD 2'h3
`define PIOC_CTL  14:5
`define PIOC_STB  14:13
`define PIOC_ODIR 12
`define PIOC_IDIR 11
`define PIOC_SC   10
`define PIOC_EN   9:5
`define STAT_IBF  4
`define RST_ZERO16 16'h0000
`endif

// [hdl/dsp_instruction_decoder.v]
// Purpose: Decodes 16-bit instruction words and holds four control registers.
// Assumes: Instruction words and register moves come from logic on core_clk_in.
// Notes:   Decoding advances on the half-rate instruction clock enable.
//
// Summary of operation
// - Top five bits type; 11110 reserved.
// - Destination and source bits: 0=acc0, 1=acc1.
// - Transfer accumulator bit has inverted sense.
// - Function selects op, product forming, writeback.
// - X bit: ROM post-mode or half select.
// - Indirect code: pointer plus post-modification.
// - Compound code: pointer plus compound mode.
// - Special function code selects; 1010 reserved.
// - Condition codes to 10001; rest reserved.
// - Indirect branch kinds; top bit reserved.
// - Six-bit move register code; gaps reserved.
// - Short immediate target set chosen by type.
// - Qualifier guards following branch, except icall.
// - Immediate move takes operand as second word.
// - Slot map: receive upper byte, transmit lower.
// - Status word flags and accumulator guard bits.
// - Clear inhibit bits disable auto clearing.
// - Saturation inhibit bits per accumulator.
// - Product alignment field; 11 reserved.
// - Strobe width field T to 4T.
// - Strobe direction and status/control mode bits.
// - Interrupt enables, status, top bit mirror.
// - Zero loop instruction count means redo.
// - Narrow register reads sign or zero extend.
// - Serial control and slot registers read zero.
`timescale 1ns/1ps
`include "dspdec_defines.vh"

module dsp_instruction_decoder (
  // Clock and reset.
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  // Instruction stream.
  input  wire        instr_valid_in,
  input  wire [15:0] instr_word_in,
  // Register move port.
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [5:0]  reg_code_in,
  input  wire [15:0] reg_wdata_in,
  input  wire [15:0] reg_raw_in,
  // Hardware flag updates.
  input  wire        flag_load_in,
  input  wire [3:0]  flags_in,
  input  wire        acc_ext_load_in,
  input  wire [9:0]  acc_ext_in,
  // Parallel port status pins.
  input  wire [4:0]  port_status_in,
  // Decoded instruction.
  output reg         instr_ce_out,
  output reg         dec_valid_out,
  output reg  [3:0]  op_class_out,
  output reg         reserved_out,
  output reg         dst_acc_out,
  output reg         src_acc_out,
  output reg  [3:0]  func_code_out,
  output reg         product_update_out,
  output reg         acc_write_out,
  output reg         x_is_rom_out,
  output reg         x_bit_out,
  output reg  [1:0]  ptr_sel_out,
  output reg  [1:0]  post_mod_out,
  output reg         compound_out,
  output reg  [4:0]  condition_code_out,
  output reg         cond_exec_out,
  output reg         event_counter_out,
  output reg  [1:0]  branch_kind_out,
  output reg  [5:0]  reg_code_out,
  output reg  [15:0] operand_out,
  output reg  [3:0]  loop_instruction_count_out,
  output reg         loop_redo_out,
  // Register read answer.
  output reg         rd_valid_out,
  output reg  [15:0] reg_rdata_out,
  // Control register contents.
  output reg  [7:0]  rx_addr_enable_out,
  output reg  [7:0]  tx_addr_enable_out,
  output reg  [2:0]  clear_inhibit_bits_out,
  output reg  [1:0]  saturation_inhibit_bits_out,
  output reg  [1:0]  product_align_out,
  output reg         align_reserved_out,
  output reg  [1:0]  strobe_width_out,
  output reg         parallel_out_strobe_out,
  output reg         parallel_in_strobe_out,
  output reg         status_control_mode_out,
  output reg  [4:0]  irq_enable_out
);

  localparam ST_OP     = 3'h1;
  localparam ST_IMM    = 3'h2;
  localparam ST_BRANCH = 3'h4;

  reg  [1:0]  rst_sync;
  reg  [4:0]  stat_meta;
  reg  [4:0]  stat_sync;
  reg  [2:0]  state;
  reg  [5:0]  saved_reg;
  reg  [4:0]  saved_con;
  reg  [15:0] psw;
  wire        rst_n;
  wire [4:0]  t;
  wire [15:0] w;
  wire        take;
  wire        is_branch;

  assign rst_n     = rst_sync[1];
  assign w         = instr_word_in;
  assign t         = instr_word_in[`F_T];
  assign take      = instr_ce_out & instr_valid_in;
  assign is_branch = (t[3:1] == 3'h0) | (t == 5'h18);

  // Multiply/ALU group types.
  function is_mac;
    input [4:0] ty;
    begin
      case (ty)
        5'h04, 5'h05, 5'h06, 5'h07, 5'h14, 5'h15, 5'h16, 5'h17,
        5'h19, 5'h1B, 5'h1C, 5'h1D, 5'h1F: is_mac = 1'b1;
        default: is_mac = 1'b0;
      endcase
    end
  endfunction

  // Register codes that name nothing.
  function reg_rsvd;
    input [5:0] code;
    begin
      reg_rsvd = (code > `R_MAX) | ((code >= `R_GAP_LO) & (code <= `R_GAP_HI));
    end
  endfunction

  // Widens a narrow register by its signedness.
  function [15:0] extend;
    input [5:0]  code;
    input [15:0] raw;
    begin
      case (code)
        `R_J, `R_K:               extend = {{7{raw[8]}}, raw[8:0]};
        `R_I:                     extend = {{4{raw[11]}}, raw[11:0]};
        6'h15, 6'h16, 6'h17:      extend = {{8{raw[7]}}, raw[7:0]};
        6'h00, 6'h01, 6'h02, 6'h03,
        6'h06, 6'h07:             extend = {7'h00, raw[8:0]};
        default:                  extend = raw;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  // Reset asserts at once and releases after two edges.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // Parallel status pins pass two flip-flops.
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stat_meta <= 5'h00;
      stat_sync <= 5'h00;
    end else begin
      stat_meta <= port_status_in;
      stat_sync <= stat_meta;
    end
  end

  // Instruction clock enable at half the input rate.
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      instr_ce_out <= 1'b0;
    end else begin
      instr_ce_out <= ~instr_ce_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Software writes; hardware flag loads land after them so they win.
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      psw                         <= `RST_ZERO16;
      rx_addr_enable_out          <= 8'h00;
      tx_addr_enable_out          <= 8'h00;
      clear_inhibit_bits_out      <= 3'h0;
      saturation_inhibit_bits_out <= 2'h0;
      product_align_out           <= 2'h0;
      align_reserved_out          <= 1'b0;
      strobe_width_out            <= 2'h0;
      parallel_out_strobe_out     <= 1'b0;
      parallel_in_strobe_out      <= 1'b0;
      status_control_mode_out     <= 1'b0;
      irq_enable_out              <= 5'h00;
    end else begin
      if (reg_wr_in) begin
        case (reg_code_in)
          `R_SRTA: begin
            rx_addr_enable_out <= reg_wdata_in[`SRTA_RX];
            tx_addr_enable_out <= reg_wdata_in[`SRTA_TX];
          end
          `R_PSW: begin
            psw[`PSW_FLAGS] <= reg_wdata_in[`PSW_FLAGS];
            psw[`PSW_ACC]   <= reg_wdata_in[`PSW_ACC];
          end
          `R_AUC: begin
            clear_inhibit_bits_out      <= reg_wdata_in[`AUC_CLR];
            saturation_inhibit_bits_out <= reg_wdata_in[`AUC_SAT];
            product_align_out           <= reg_wdata_in[`AUC_ALIGN];
            align_reserved_out          <= reg_wdata_in[`AUC_ALIGN] == `ALIGN_RSVD;
          end
          `R_PIOC: begin
            strobe_width_out        <= reg_wdata_in[`PIOC_STB];
            parallel_out_strobe_out <= reg_wdata_in[`PIOC_ODIR];
            parallel_in_strobe_out  <= reg_wdata_in[`PIOC_IDIR];
            status_control_mode_out <= reg_wdata_in[`PIOC_SC];
            irq_enable_out          <= reg_wdata_in[`PIOC_EN];
          end
          default: begin
          end
        endcase
      end
      if (flag_load_in) begin
        psw[`PSW_FLAGS] <= flags_in;
      end
      if (acc_ext_load_in) begin
        psw[`PSW_ACC] <= acc_ext_in;
      end
    end
  end

  // Register reads answer one cycle later.
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_out  <= 1'b0;
      reg_rdata_out <= `RST_ZERO16;
    end else begin
      rd_valid_out <= reg_rd_in;
      if (reg_rd_in) begin
        if (reg_rsvd(reg_code_in)) begin
          reg_rdata_out <= `RST_ZERO16;
        end else begin
          case (reg_code_in)
            `R_PSW:  reg_rdata_out <= psw;
            `R_AUC:  reg_rdata_out <= {9'h000, clear_inhibit_bits_out,
                                       saturation_inhibit_bits_out, product_align_out};
            `R_PIOC: reg_rdata_out <= {stat_sync[`STAT_IBF], strobe_width_out, parallel_out_strobe_out,
                                       parallel_in_strobe_out, status_control_mode_out,
                                       irq_enable_out, stat_sync};
            `R_SIOC, `R_SRTA, `R_TDMS: reg_rdata_out <= `RST_ZERO16;
            default: reg_rdata_out <= extend(reg_code_in, reg_raw_in);
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode and two-word sequencing.

  // Fields are registered on each taken word; class picks their meaning.
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state                      <= ST_OP;
      saved_reg                  <= 6'h00;
      saved_con                  <= 5'h00;
      dec_valid_out              <= 1'b0;
      op_class_out               <= `C_NOP;
      reserved_out               <= 1'b0;
      dst_acc_out                <= 1'b0;
      src_acc_out                <= 1'b0;
      func_code_out              <= 4'h0;
      product_update_out         <= 1'b0;
      acc_write_out              <= 1'b0;
      x_is_rom_out               <= 1'b0;
      x_bit_out                  <= 1'b0;
      ptr_sel_out                <= 2'h0;
      post_mod_out               <= 2'h0;
      compound_out               <= 1'b0;
      condition_code_out         <= 5'h00;
      cond_exec_out              <= 1'b0;
      event_counter_out          <= 1'b0;
      branch_kind_out            <= 2'h0;
      reg_code_out               <= 6'h00;
      operand_out                <= `RST_ZERO16;
      loop_instruction_count_out <= 4'h0;
      loop_redo_out              <= 1'b0;
    end else begin
      dec_valid_out <= 1'b0;
      if (take) begin
        dec_valid_out              <= 1'b1;
        state                      <= ST_OP;
        op_class_out               <= `C_NOP;
        reserved_out               <= 1'b0;
        cond_exec_out              <= 1'b0;
        event_counter_out          <= 1'b0;
        product_update_out         <= 1'b0;
        acc_write_out              <= 1'b0;
        loop_redo_out              <= 1'b0;
        dst_acc_out                <= w[`F_ACC];
        src_acc_out                <= w[`F_SRC];
        func_code_out              <= w[`F_FUNC];
        x_bit_out                  <= w[`F_X];
        x_is_rom_out               <= t[4] & t[3] & t[0];
        ptr_sel_out                <= w[`F_PTR];
        post_mod_out               <= w[`F_MOD];
        compound_out               <= t[2:0] == 3'h5;
        condition_code_out         <= w[`F_CON];
        branch_kind_out            <= w[`F_B_KIND];
        reg_code_out               <= w[`F_R];
        operand_out                <= w;
        loop_instruction_count_out <= w[`F_NI];
        if (state == ST_IMM) begin
          op_class_out <= reg_rsvd(saved_reg) ? `C_NOP : `C_IMM;
          reserved_out <= reg_rsvd(saved_reg);
          reg_code_out <= saved_reg;
        end else begin
          case (t)
            5'h00, 5'h01: begin
              op_class_out <= `C_JUMP;
              operand_out  <= {4'h0, w[`F_JA]};
            end
            5'h10, 5'h11: begin
              op_class_out <= `C_CALL;
              operand_out  <= {4'h0, w[`F_JA]};
            end
            5'h02, 5'h03: begin
              op_class_out <= `C_SHORT;
              reg_code_out <= {3'h0, ~t[0], w[`F_I]};
              operand_out  <= {7'h00, w[`F_M]};
            end
            5'h12, 5'h13: begin
              cond_exec_out     <= 1'b1;
              event_counter_out <= ~t[0];
              if ((w[`F_FUNC] == `F2_RSVD) | (w[`F_CON] > `CON_MAX)) begin
                reserved_out <= 1'b1;
              end else begin
                op_class_out <= `C_SPECIAL;
              end
              // Code 0101 passes unflagged as shift left by eight.
              if (w[`F_FUNC] == `F2_SHL8) begin
                func_code_out <= `F2_SHL8;
              end
            end
            5'h18: begin
              if (w[`F_B_TOP]) begin
                reserved_out <= 1'b1;
              end else begin
                op_class_out <= `C_BR_IND;
              end
            end
            5'h1A: begin
              if (w[`F_SI]) begin
                op_class_out <= `C_SWI;
              end else begin
                dec_valid_out <= 1'b0;
                saved_con     <= w[`F_CON];
                state         <= ST_BRANCH;
              end
            end
            5'h08, 5'h09, 5'h0B, 5'h0C, 5'h0D, 5'h0F: begin
              op_class_out <= reg_rsvd(w[`F_R]) ? `C_NOP : `C_MOVE;
              reserved_out <= reg_rsvd(w[`F_R]);
              if (t == 5'h08) begin
                dst_acc_out <= ~w[`F_ACC];
              end
            end
            5'h0A: begin
              dec_valid_out <= 1'b0;
              saved_reg     <= w[`F_R];
              state         <= ST_IMM;
            end
            5'h0E: begin
              op_class_out  <= `C_CACHE;
              loop_redo_out <= w[`F_NI] == 4'h0;
              operand_out   <= {9'h000, w[`F_K]};
            end
            default: begin
              if (is_mac(t)) begin
                op_class_out       <= `C_MAC;
                product_update_out <= w[`F_F1_HI] == 2'h0;
                acc_write_out      <= (w[`F_FUNC] != `F1_NOP) & (w[`F_FUNC] != `F1_PONLY) &
                                      (w[`F_FUNC] != `F1_TAND) & (w[`F_FUNC] != `F1_TSUB);
                if ((t == 5'h05) | (t == 5'h07)) begin
                  dst_acc_out <= ~w[`F_ACC];
                end
              end else begin
                reserved_out <= 1'b1;
              end
            end
          endcase
          // The word after a qualifier runs only if it is a branch.
          if (state == ST_BRANCH) begin
            state              <= ST_OP;
            dec_valid_out      <= 1'b1;
            cond_exec_out      <= 1'b1;
            condition_code_out <= saved_con;
            if (!is_branch | (saved_con > `CON_MAX)) begin
              op_class_out <= `C_NOP;
              reserved_out <= 1'b1;
            end
          end
        end
      end
    end
  end

endmodule

// [dv/dec_checker_assertions.sv]
// Purpose: Checks on decoder ports.
// Assumes: Bound into every decoder instance.
// Notes:   Decode antecedents skip the second word of two-word forms.
`timescale 1ns/1ps
module dec_checker (
  // Clock and reset.
  input wire        core_clk_in,
  input wire        rst_n_in,
  // Decoder inputs.
  input wire        instr_valid_in,
  input wire [15:0] instr_word_in,
  input wire        reg_rd_in,
  input wire [5:0]  reg_code_in,
  // Decoder outputs.
  input wire        instr_ce_out,
  input wire        dec_valid_out,
  input wire [3:0]  op_class_out,
  input wire        reserved_out,
  input wire        dst_acc_out,
  input wire        src_acc_out,
  input wire        product_update_out,
  input wire        acc_write_out,
  input wire        loop_redo_out,
  input wire [15:0] operand_out,
  input wire        rd_valid_out,
  input wire [15:0] reg_rdata_out,
  input wire [1:0]  product_align_out,
  input wire        align_reserved_out
);
  reg  [15:0] wd;
  reg         after_q;
  reg         after_i;
  wire        take  = instr_ce_out && instr_valid_in;
  wire        fresh = take && !after_q && !after_i;
  wire [4:0]  ty    = instr_word_in[15:11];
  // Track second words.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd      <= 16'h0000;
      after_q <= 1'b0;
      after_i <= 1'b0;
    end else begin
      wd <= instr_word_in;
      if (take) begin
        after_q <= fresh && ty == 5'h1A && !instr_word_in[10];
        after_i <= fresh && ty == 5'h0A;
      end
    end
  end
  ////////////////////////////////////////
  default clocking dcb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_jump_decode: assert property (fresh && ty[4:1] == 4'h0 |=>
    dec_valid_out && op_class_out == 4'h1 && operand_out == {4'h0, wd[11:0]}) else $error("Bad jump.");
  a_call_decode: assert property (fresh && ty[4:1] == 4'h8 |=>
    dec_valid_out && op_class_out == 4'h2) else $error("Bad call.");
  a_reserved_type: assert property (fresh && ty == 5'h1E |=>
    dec_valid_out && reserved_out && op_class_out == 4'h0) else $error("Type not flagged.");
  a_reserved_nop: assert property (dec_valid_out && reserved_out |->
    op_class_out == 4'h0) else $error("Reserved not a no-op.");
  a_acc_select: assert property (fresh && ty == 5'h04 |=>
    dst_acc_out == wd[10] && src_acc_out == wd[9]) else $error("Bad acc select.");
  a_transfer_invert: assert property (fresh && ty == 5'h07 |=>
    dst_acc_out == !wd[10]) else $error("Transfer select wrong.");
  a_product_form: assert property (fresh && ty == 5'h04 |=>
    product_update_out == (wd[8:7] == 2'b00) && acc_write_out == !(wd[8:5] inside {4'h2, 4'h6, 4'hA, 4'hB}))
    else $error("MAC flags wrong.");
  a_redo_zero: assert property (fresh && ty == 5'h0E |=>
    loop_redo_out == (wd[10:7] == 4'h0)) else $error("Bad redo.");
  a_read_answer: assert property (reg_rd_in |=> rd_valid_out) else $error("No read answer.");
  a_read_pulse: assert property (rd_valid_out && !reg_rd_in |=> !rd_valid_out) else $error("Read valid stuck.");
  a_unreadable_zero: assert property (reg_rd_in && reg_code_in inside {6'h18, 6'h19, 6'h1B} |=>
    reg_rdata_out == 16'h0000) else $error("Write-only read nonzero.");
  a_align_flag: assert property (align_reserved_out == (product_align_out == 2'b11))
    else $error("Align flag wrong.");
endmodule

bind dsp_instruction_decoder dec_checker i_chk (.*);

// [dv/prog_mem_model.sv]
// Purpose: Program memory feeding instruction words.
// Assumes: Words change on the falling edge.
// Notes:   Idle word lines invert their value on each idle falling edge unless go_in is high.
`timescale 1ns/1ps
module prog_mem_model (
  // Clock and control.
  input  wire        clk_in,
  input  wire        ce_in,
  input  wire        go_in,
  input  wire [4:0]  count_in,
  // Instruction stream.
  output reg         valid_out,
  output reg  [15:0] word_out,
  output wire        done_out
);
  reg [15:0] mem [0:31];
  reg [4:0]  pc;
  assign done_out = (pc == count_in);
  initial begin
    valid_out = 1'b0;
    word_out  = 16'h0000;
    pc        = 5'h00;
  end
  // Offer words only in taken slots.
  always @(negedge clk_in) begin
    if (go_in) begin
      pc        <= 5'h00;
      valid_out <= 1'b0;
    end else if (ce_in && pc < count_in) begin
      valid_out <= 1'b1;
      word_out  <= mem[pc];
      pc        <= pc + 5'h01;
    end else begin
      valid_out <= 1'b0;
      word_out  <= ~word_out;
    end
  end
endmodule

// [dv/testbench.sv]
// Purpose: Self-checking bench for the instruction decoder.
// Assumes: Inputs change on the falling edge.
// Notes:   Decoded fields queue on each valid pulse.
`timescale 1ns/1ps
module testbench;
  logic        core_clk_in, rst_n_in, reg_wr_in, reg_rd_in, flag_load_in, acc_ext_load_in, go;
  logic [5:0]  reg_code_in;
  logic [15:0] reg_wdata_in, reg_raw_in;
  logic [3:0]  flags_in;
  logic [9:0]  acc_ext_in;
  logic [4:0]  port_status_in, cnt;
  wire         instr_valid_in, done, instr_ce_out, dec_valid_out, reserved_out, dst_acc_out, src_acc_out;
  wire         product_update_out, acc_write_out, cond_exec_out, loop_redo_out, rd_valid_out, align_reserved_out;
  wire         parallel_out_strobe_out, parallel_in_strobe_out, status_control_mode_out;
  wire  [3:0]  op_class_out;
  wire  [15:0] instr_word_in, operand_out, reg_rdata_out;
  wire  [7:0]  rx_addr_enable_out, tx_addr_enable_out;
  wire  [2:0]  clear_inhibit_bits_out;
  wire  [1:0]  saturation_inhibit_bits_out, product_align_out, strobe_width_out;
  wire  [4:0]  irq_enable_out;
  logic [26:0] dq[$];
  logic [15:0] prog[$];
  int          n_errors, check_count, cycles;
  localparam logic [26:0] MB = {4'hF, 7'h60, 16'hFFFF};
  localparam logic [26:0] MR = {4'hF, 7'h40, 16'h0000};
  localparam logic [26:0] MM = {4'hF, 7'h1E, 16'h0000};
  localparam logic [26:0] ML = {4'hF, 7'h01, 16'hFFFF};
  dsp_instruction_decoder i_dut (.*, .func_code_out(), .x_is_rom_out(), .x_bit_out(), .ptr_sel_out(),
    .post_mod_out(), .compound_out(), .condition_code_out(), .event_counter_out(), .branch_kind_out(),
    .reg_code_out(), .loop_instruction_count_out());
  prog_mem_model i_mem (.clk_in(core_clk_in), .ce_in(instr_ce_out), .go_in(go), .count_in(cnt),
    .valid_out(instr_valid_in), .word_out(instr_word_in), .done_out(done));
  ////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Queue decoded fields; cut hangs.
  always @(negedge core_clk_in) begin
    if (dec_valid_out === 1'b1)
      dq.push_back({op_class_out, reserved_out, cond_exec_out, dst_acc_out, src_acc_out, product_update_out,
                    acc_write_out, loop_redo_out, operand_out});
  end
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_dec(input logic [26:0] exp, input logic [26:0] msk);
    logic [26:0] got;
    got = (dq.size() > 0) ? dq.pop_front() : 27'hx;
    check(got & msk, exp & msk);
  endtask
  task automatic run_prog;
    int k;
    for (k = 0; k < prog.size(); k++)
      i_mem.mem[k] = prog[k];
    dq.delete();
    cnt <= 5'(prog.size());
    go  <= 1'b1;
    @(negedge core_clk_in);
    go <= 1'b0;
    @(negedge core_clk_in);
    for (k = 0; k < 80 && done !== 1'b1; k++)
      @(negedge core_clk_in);
    repeat (3) @(negedge core_clk_in);
  endtask
  task automatic reg_write(input logic [5:0] code, input logic [15:0] data);
    @(negedge core_clk_in);
    reg_wr_in    = 1'b1;
    reg_code_in  = code;
    reg_wdata_in = data;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic reg_read(input logic [5:0] code, input logic [15:0] raw, input logic [15:0] exp);
    @(negedge core_clk_in);
    reg_rd_in   = 1'b1;
    reg_code_in = code;
    reg_raw_in  = raw;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    check({rd_valid_out, reg_rdata_out}, {1'b1, exp});
  endtask
  ////////////////////////////////////////
  task automatic t_branch;
    prog = '{16'h0ABC, 16'h8123, 16'hF000, 16'hC000, 16'hC400, 16'hD00E, 16'h0055, 16'hD01F, 16'h0055,
             16'hD400, 16'h0066};
    run_prog();
    expect_dec({4'h1, 7'h00, 16'h0ABC}, MB);
    expect_dec({4'h2, 7'h00, 16'h0123}, MB);
    expect_dec({4'h0, 7'h40, 16'h0000}, MR);
    expect_dec({4'h5, 7'h00, 16'h0000}, MR);
    expect_dec({4'h0, 7'h40, 16'h0000}, MR);
    expect_dec({4'h1, 7'h20, 16'h0055}, MB);
    expect_dec({4'h0, 7'h40, 16'h0000}, MR);
    expect_dec({4'h6, 7'h00, 16'h0000}, MR);
    expect_dec({4'h1, 7'h00, 16'h0066}, MB);
    $display("t_branch finished");
  endtask
  task automatic t_mac;
    prog = '{16'h2400, 16'h2340, 16'h20C0, 16'h3800, 16'h2200, 16'h2040, 16'h9800, 16'h9940, 16'h9812, 16'h98A0};
    run_prog();
    expect_dec({4'h3, 7'h16, 16'h0000}, MM);
    expect_dec({4'h3, 7'h08, 16'h0000}, MM);
    expect_dec({4'h3, 7'h00, 16'h0000}, MM);
    expect_dec({4'h3, 7'h16, 16'h0000}, MM);
    expect_dec({4'h3, 7'h0E, 16'h0000}, MM);
    expect_dec({4'h3, 7'h04, 16'h0000}, MM);
    expect_dec({4'h4, 7'h00, 16'h0000}, MR);
    expect_dec({4'h0, 7'h40, 16'h0000}, MR);
    expect_dec({4'h0, 7'h40, 16'h0000}, MR);
    expect_dec({4'h4, 7'h00, 16'h0000}, MR);
    $display("t_mac finished");
  endtask
  task automatic t_move;
    prog = '{16'h5010, 16'h1234, 16'h1A05, 16'h7005, 16'h7085};
    run_prog();
    expect_dec({4'h8, 7'h00, 16'h1234}, MB);
    expect_dec({4'h9, 7'h00, 16'h0005}, MB);
    expect_dec({4'hA, 7'h01, 16'h0005}, ML);
    expect_dec({4'hA, 7'h00, 16'h0005}, ML);
    $display("t_move finished");
  endtask
  task automatic t_regs;
    reg_write(6'h13, 16'h0065);
    check(clear_inhibit_bits_out, 3'h6);
    check(saturation_inhibit_bits_out, 2'h1);
    check({product_align_out, align_reserved_out}, 3'h2);
    reg_read(6'h13, 16'hFFFF, 16'h0065);
    reg_write(6'h13, 16'h0003);
    check({product_align_out, align_reserved_out}, 3'h7);
    reg_write(6'h19, 16'hA55A);
    check({rx_addr_enable_out, tx_addr_enable_out}, 16'hA55A);
    reg_read(6'h19, 16'h1234, 16'h0000);
    reg_write(6'h1C, 16'h5A60);
    check({strobe_width_out, parallel_out_strobe_out, parallel_in_strobe_out, status_control_mode_out,
           irq_enable_out}, 10'h2D3);
    reg_read(6'h1C, 16'h0000, 16'hDA71);
    @(negedge core_clk_in);
    {flag_load_in, flags_in, acc_ext_load_in, acc_ext_in} = {1'b1, 4'hA, 1'b1, 10'h2AB};
    @(negedge core_clk_in);
    {flag_load_in, acc_ext_load_in} = 2'b00;
    reg_read(6'h14, 16'h0000, 16'hA2AB);
    reg_write(6'h14, 16'h5FFF);
    reg_read(6'h14, 16'h0000, 16'h53FF);
    reg_read(6'h04, 16'h0100, 16'hFF00);
    reg_read(6'h00, 16'hFF80, 16'h0180);
    reg_read(6'h0C, 16'h1234, 16'h0000);
    $display("t_regs finished");
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, flag_load_in, acc_ext_load_in, go, cnt} = 11'h000;
    {reg_code_in, reg_wdata_in, reg_raw_in, flags_in, acc_ext_in} = 52'h0;
    port_status_in = 5'h11;
    repeat (20) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    t_branch();
    t_mac();
    t_move();
    t_regs();
    stop_test();
  end
endmodule
